// >>> rtl/asp2_pkg.sv
package asp2_pkg;
  // ****************************************
  // Register indices (byte address is four times the index)
  // ****************************************
  localparam logic [15:0] IDX_RX_CTRL = 16'hfee8;
  localparam logic [15:0] IDX_TX_CTRL = 16'hfee9;
  localparam logic [15:0] IDX_BAUD    = 16'hfeea;
  localparam logic [15:0] IDX_TX_HOLD = 16'hfeeb;
  localparam logic [15:0] IDX_RX_HOLD = 16'hfeec;
  localparam logic [7:0]  RESET_VAL   = 8'h00;
  // ****************************************
  // Receive control/status fields
  // ****************************************
  localparam int RX_PERIOD_SEL = 7;
  localparam int RX_START_EN   = 6;
  localparam int RX_RUNNING    = 5;
  localparam int RX_STOP_ERR   = 4;
  localparam int RX_GP_FLAG    = 3;
  localparam int RX_NINTH      = 2;
  localparam int RX_DONE       = 1;
  localparam int RX_IRQ_EN     = 0;
  // ****************************************
  // Transmit control/status fields
  // ****************************************
  localparam int TX_RUNNING    = 7;
  localparam int TX_LEN_HIGH   = 6;
  localparam int TX_PIN_DRIVE  = 5;
  localparam int TX_PUSH_PULL  = 4;
  localparam int TX_LEN_LOW    = 3;
  localparam int TX_NINTH      = 2;
  localparam int TX_LOADED     = 1;
  localparam int TX_IRQ_EN     = 0;
  // ****************************************
  // Baud scaling: period is (n+1)*NUM/DEN cycles
  // ****************************************
  localparam logic [14:0] BAUD_NUM_SLOW = 15'h0020;
  localparam logic [14:0] BAUD_NUM_FAST = 15'h0008;
  localparam logic [14:0] BAUD_DEN      = 15'h0003;
  localparam logic [14:0] BAUD_HALF_INC = 15'h0006;
  // ****************************************
  // Frame lengths and bus answers
  // ****************************************
  localparam logic [3:0] LEN_7  = 4'h7;
  localparam logic [3:0] LEN_8  = 4'h8;
  localparam logic [3:0] LEN_9  = 4'h9;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LOAD = 2'b01,
    TX_SEND = 2'b10
  } asp2_tx_state_e;
endpackage : asp2_pkg

// >>> rtl/asp2_uart.sv
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Baud tick every (reload+1)*32/3 cycles if period select set, else *8/3.
// - Baud counter reinitialised while receive and transmit both stopped.
// - Transmitter and receiver share one baud rate and one frame length.
// - Enabling start detect while receive pin low and done clear starts reception at once.
// - Falling edge on receive pin with detection enabled starts reception.
// - Receive running clears at frame end; software clear aborts reception.
// - Abort still sets done, copies shifter, flags error if last bit low.
// - Stop error set at frame end if stop bit low; software clears it.
// - Ninth bit stored in 9-bit mode; on abort second-to-last bit.
// - Frame end sets receive done and fills receive holding register.
// - Low receive pin without a falling edge does not launch next reception while done is set.
// - Receive interrupt request while receive irq enable and done both set.
// - Setting transmit running starts frame; clears at end; clear aborts.
// - Continuous transmit keeps running set, giving a one-cycle gap between frames.
// - Transmit control write in the auto-clear cycle cancels the continuous restart.
// - Length bits: 10 nine, 00 eight, 01 seven; bit 7 zero for seven.
// - Pin drive routes output, idles high/open; push-pull select picks type.
// - Transmit loaded flag set one cycle after running set, on shifter load.
// - Software clears loaded flag after refill; that requests continuous restart.
// - Transmit interrupt request while transmit irq enable and loaded set.
// - LSB first, no parity, one stop bit, two in continuous transmission.
module asp2_uart #(
  parameter int ADDR_W = 18
) (
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_resetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  // AXI4-Lite write response
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  // Serial pins
  input  wire logic              i_receive_pin,
  output logic                   o_transmit_pin,
  output logic                   o_transmit_pin_oe,
  // Interrupt requests
  output logic                   o_rx_irq,
  output logic                   o_tx_irq
);
  initial begin
    if (ADDR_W < 18 || ADDR_W > 32) begin
      $error("ADDR_W must lie in 18..32");
    end
  end

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    reg_sel = 3'h0;
    if (a[1:0] == 2'b00) begin
      if (idx == (ADDR_W-2)'(asp2_pkg::IDX_RX_CTRL)) reg_sel = 3'h1;
      if (idx == (ADDR_W-2)'(asp2_pkg::IDX_TX_CTRL)) reg_sel = 3'h2;
      if (idx == (ADDR_W-2)'(asp2_pkg::IDX_BAUD))    reg_sel = 3'h3;
      if (idx == (ADDR_W-2)'(asp2_pkg::IDX_TX_HOLD)) reg_sel = 3'h4;
      if (idx == (ADDR_W-2)'(asp2_pkg::IDX_RX_HOLD)) reg_sel = 3'h5;
    end
  endfunction : reg_sel

  function automatic logic [3:0] frame_len(input logic hi, input logic lo);
    frame_len = asp2_pkg::LEN_8;
    if (hi && !lo) frame_len = asp2_pkg::LEN_9;
    if (!hi && lo) frame_len = asp2_pkg::LEN_7;
  endfunction : frame_len

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0]              rx_ctrl_r;
  logic [7:0]              tx_ctrl_r;
  logic [7:0]              baud_reload_r;
  logic [7:0]              tx_hold_r;
  logic [7:0]              rx_hold_r;
  logic                    aw_v_r, w_v_r;
  logic [ADDR_W-1:0]       aw_addr_r;
  logic [31:0]             w_data_r;
  logic                    w_strb0_r;
  logic                    bvalid_r, rvalid_r, arready_r;
  logic [1:0]              bresp_r, rresp_r;
  logic [31:0]             rdata_r;
  logic [14:0]             baud_acc_r;
  logic                    half_tick_r;
  asp2_pkg::asp2_tx_state_e tx_state_r;
  logic [10:0]             tx_shift_r;
  logic [3:0]              tx_cnt_r;
  logic                    tx_ph_r, tx_extra_r;
  logic [9:0]              rx_shift_r;
  logic [3:0]              rx_cnt_r;
  logic                    rx_ph_r, rx_last_r, rx_prev_r, rx_pin_d_r;
  logic                    txd_r, txd_oe_r, rx_irq_r, tx_irq_r;

  logic       wr_en;
  logic [2:0] wr_sel;
  logic       wr_rx_ctrl, wr_tx_ctrl;
  logic [7:0] wb;
  logic       rx_run, tx_run;
  logic [3:0] len;
  logic [14:0] baud_thr, baud_sum;
  logic       rx_start, rx_sample, rx_end, rx_abort, rx_done_set;
  logic       tx_full_tick, tx_last_bit, tx_finish, tx_restart, tx_abort;

  assign wr_en      = aw_v_r && w_v_r && !bvalid_r;
  assign wr_sel     = reg_sel(aw_addr_r);
  assign wb         = w_data_r[7:0];
  assign wr_rx_ctrl = wr_en && w_strb0_r && (wr_sel == 3'h1);
  assign wr_tx_ctrl = wr_en && w_strb0_r && (wr_sel == 3'h2);
  assign rx_run     = rx_ctrl_r[asp2_pkg::RX_RUNNING];
  assign tx_run     = tx_ctrl_r[asp2_pkg::TX_RUNNING];
  assign len        = frame_len(tx_ctrl_r[asp2_pkg::TX_LEN_HIGH],
                                tx_ctrl_r[asp2_pkg::TX_LEN_LOW]);

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_v_r    <= 1'b0;
      w_v_r     <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb0_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= asp2_pkg::RESP_OKAY;
    end else begin
      if (i_awvalid && !aw_v_r) begin
        aw_v_r    <= 1'b1;
        aw_addr_r <= i_awaddr;
      end
      if (i_wvalid && !w_v_r) begin
        w_v_r     <= 1'b1;
        w_data_r  <= i_wdata;
        w_strb0_r <= i_wstrb[0];
      end
      if (wr_en) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (wr_sel == 3'h0) ? asp2_pkg::RESP_SLVERR : asp2_pkg::RESP_OKAY;
      end
      if (bvalid_r && i_bready) begin
        bvalid_r <= 1'b0;
        aw_v_r   <= 1'b0;
        w_v_r    <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= asp2_pkg::RESP_OKAY;
    end else if (arready_r && i_arvalid) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= asp2_pkg::RESP_OKAY;
      case (reg_sel(i_araddr))
        3'h1:    rdata_r <= {24'h0000_00, rx_ctrl_r};
        3'h2:    rdata_r <= {24'h0000_00, tx_ctrl_r};
        3'h3:    rdata_r <= {24'h0000_00, baud_reload_r};
        3'h4:    rdata_r <= {24'h0000_00, tx_hold_r};
        3'h5:    rdata_r <= {24'h0000_00, rx_hold_r};
        default: begin
          rdata_r <= '0;
          rresp_r <= asp2_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && i_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ****************************************
  // Baud generator (half-bit ticks)
  // ****************************************
  assign baud_thr = (15'(baud_reload_r) + 15'h0001) *
                    (rx_ctrl_r[asp2_pkg::RX_PERIOD_SEL] ?
                     asp2_pkg::BAUD_NUM_SLOW : asp2_pkg::BAUD_NUM_FAST);
  assign baud_sum = baud_acc_r + asp2_pkg::BAUD_HALF_INC;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      baud_acc_r  <= '0;
      half_tick_r <= 1'b0;
    end else if (!rx_run && !tx_run) begin
      baud_acc_r  <= '0;
      half_tick_r <= 1'b0;
    end else if (baud_sum >= baud_thr) begin
      baud_acc_r  <= baud_sum - baud_thr;
      half_tick_r <= 1'b1;
    end else begin
      baud_acc_r  <= baud_sum;
      half_tick_r <= 1'b0;
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  assign rx_start    = rx_ctrl_r[asp2_pkg::RX_START_EN] && !rx_run && !i_receive_pin &&
                       (rx_pin_d_r || !rx_ctrl_r[asp2_pkg::RX_START_EN] ||
                        !rx_ctrl_r[asp2_pkg::RX_DONE]);
  assign rx_sample   = rx_run && half_tick_r && rx_ph_r;
  assign rx_end      = rx_sample && (rx_cnt_r == len + 4'h1);
  assign rx_abort    = rx_run && wr_rx_ctrl && !wb[asp2_pkg::RX_RUNNING] && !rx_end;
  assign rx_done_set = rx_end || rx_abort;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_pin_d_r <= 1'b1;
      rx_shift_r <= '0;
      rx_cnt_r   <= '0;
      rx_ph_r    <= 1'b0;
      rx_last_r  <= 1'b1;
      rx_prev_r  <= 1'b1;
    end else begin
      rx_pin_d_r <= i_receive_pin;
      if (rx_start) begin
        rx_shift_r <= '0;
        rx_cnt_r   <= '0;
        rx_ph_r    <= 1'b1;
      end else if (rx_run && half_tick_r) begin
        rx_ph_r <= !rx_ph_r;
        if (rx_ph_r) begin
          rx_cnt_r  <= rx_cnt_r + 4'h1;
          rx_last_r <= i_receive_pin;
          rx_prev_r <= rx_last_r;
          if (rx_cnt_r != 4'h0) begin
            rx_shift_r[rx_cnt_r - 4'h1] <= i_receive_pin;
          end
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_ctrl_r <= asp2_pkg::RESET_VAL;
      rx_hold_r <= asp2_pkg::RESET_VAL;
    end else begin
      if (wr_rx_ctrl) begin
        rx_ctrl_r[asp2_pkg::RX_PERIOD_SEL] <= wb[asp2_pkg::RX_PERIOD_SEL];
        rx_ctrl_r[asp2_pkg::RX_START_EN]   <= wb[asp2_pkg::RX_START_EN];
        rx_ctrl_r[asp2_pkg::RX_GP_FLAG]    <= wb[asp2_pkg::RX_GP_FLAG];
        rx_ctrl_r[asp2_pkg::RX_IRQ_EN]     <= wb[asp2_pkg::RX_IRQ_EN];
      end
      if (wr_en && w_strb0_r && wr_sel == 3'h5) begin
        rx_hold_r <= wb;
      end
      // Hardware set wins over a software clear in the same cycle
      rx_ctrl_r[asp2_pkg::RX_STOP_ERR] <= (wr_rx_ctrl ? wb[asp2_pkg::RX_STOP_ERR] :
        rx_ctrl_r[asp2_pkg::RX_STOP_ERR]) ||
        (rx_end && !i_receive_pin) || (rx_abort && !rx_last_r);
      rx_ctrl_r[asp2_pkg::RX_DONE] <= (wr_rx_ctrl ? wb[asp2_pkg::RX_DONE] :
        rx_ctrl_r[asp2_pkg::RX_DONE]) || rx_done_set;
      if (rx_end && len == asp2_pkg::LEN_9) begin
        rx_ctrl_r[asp2_pkg::RX_NINTH] <= rx_shift_r[8];
      end else if (rx_abort && len == asp2_pkg::LEN_9) begin
        rx_ctrl_r[asp2_pkg::RX_NINTH] <= rx_prev_r;
      end else if (wr_rx_ctrl) begin
        rx_ctrl_r[asp2_pkg::RX_NINTH] <= wb[asp2_pkg::RX_NINTH];
      end
      if (rx_done_set) begin
        rx_hold_r <= {rx_shift_r[7] && len != asp2_pkg::LEN_7, rx_shift_r[6:0]};
      end
      if (rx_done_set) begin
        rx_ctrl_r[asp2_pkg::RX_RUNNING] <= 1'b0;
      end else if (rx_start && !(wr_rx_ctrl && !wb[asp2_pkg::RX_START_EN])) begin
        rx_ctrl_r[asp2_pkg::RX_RUNNING] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  assign tx_full_tick = (tx_state_r == asp2_pkg::TX_SEND) && half_tick_r && tx_ph_r;
  assign tx_last_bit  = tx_full_tick && (tx_cnt_r == 4'h1);
  assign tx_finish    = tx_last_bit && (tx_extra_r || tx_ctrl_r[asp2_pkg::TX_LOADED]);
  assign tx_restart   = tx_finish && !tx_ctrl_r[asp2_pkg::TX_LOADED] && !wr_tx_ctrl;
  assign tx_abort     = tx_run && wr_tx_ctrl && !wb[asp2_pkg::TX_RUNNING];

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_state_r <= asp2_pkg::TX_IDLE;
      tx_shift_r <= '1;
      tx_cnt_r   <= '0;
      tx_ph_r    <= 1'b0;
      tx_extra_r <= 1'b0;
    end else begin
      case (tx_state_r)
        asp2_pkg::TX_IDLE: begin
          if (!tx_run && wr_tx_ctrl && wb[asp2_pkg::TX_RUNNING]) begin
            tx_state_r <= asp2_pkg::TX_LOAD;
          end
        end
        asp2_pkg::TX_LOAD: begin
          tx_shift_r <= {2'b11, tx_ctrl_r[asp2_pkg::TX_NINTH], tx_hold_r} << 1;
          if (len == asp2_pkg::LEN_7) begin
            tx_shift_r[8] <= 1'b1;
          end
          if (len != asp2_pkg::LEN_9) begin
            tx_shift_r[9] <= 1'b1;
          end
          tx_cnt_r   <= len + 4'h2;
          tx_ph_r    <= 1'b0;
          tx_extra_r <= 1'b0;
          tx_state_r <= asp2_pkg::TX_SEND;
        end
        asp2_pkg::TX_SEND: begin
          if (half_tick_r) begin
            tx_ph_r <= !tx_ph_r;
          end
          if (tx_full_tick) begin
            tx_shift_r <= {1'b1, tx_shift_r[10:1]};
            if (tx_cnt_r == 4'h1 && !tx_finish) begin
              tx_extra_r <= 1'b1;
            end else begin
              tx_cnt_r <= tx_cnt_r - 4'h1;
            end
          end
          if (tx_restart) begin
            tx_state_r <= asp2_pkg::TX_LOAD;
          end else if (tx_finish) begin
            tx_state_r <= asp2_pkg::TX_IDLE;
          end
        end
        default: tx_state_r <= asp2_pkg::TX_IDLE;
      endcase
      if (tx_abort) begin
        tx_state_r <= asp2_pkg::TX_IDLE;
        tx_shift_r <= '1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_ctrl_r     <= asp2_pkg::RESET_VAL;
      tx_hold_r     <= asp2_pkg::RESET_VAL;
      baud_reload_r <= asp2_pkg::RESET_VAL;
    end else begin
      if (wr_tx_ctrl) begin
        tx_ctrl_r[6:2]                   <= wb[6:2];
        tx_ctrl_r[asp2_pkg::TX_IRQ_EN]   <= wb[asp2_pkg::TX_IRQ_EN];
        tx_ctrl_r[asp2_pkg::TX_RUNNING]  <= wb[asp2_pkg::TX_RUNNING];
      end
      if (wr_en && w_strb0_r && wr_sel == 3'h3) begin
        baud_reload_r <= wb;
      end
      if (wr_en && w_strb0_r && wr_sel == 3'h4) begin
        tx_hold_r <= wb;
      end
      if (tx_finish && !tx_restart && !tx_abort) begin
        tx_ctrl_r[asp2_pkg::TX_RUNNING] <= 1'b0;
      end
      tx_ctrl_r[asp2_pkg::TX_LOADED] <= (wr_tx_ctrl ? wb[asp2_pkg::TX_LOADED] :
        tx_ctrl_r[asp2_pkg::TX_LOADED]) ||
        (tx_state_r == asp2_pkg::TX_LOAD);
    end
  end

  // ****************************************
  // Pin and interrupt outputs
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      txd_r    <= 1'b1;
      txd_oe_r <= 1'b0;
      rx_irq_r <= 1'b0;
      tx_irq_r <= 1'b0;
    end else begin
      if (!tx_ctrl_r[asp2_pkg::TX_PIN_DRIVE]) begin
        txd_r    <= 1'b1;
        txd_oe_r <= 1'b0;
      end else if (tx_ctrl_r[asp2_pkg::TX_PUSH_PULL]) begin
        txd_r    <= tx_shift_r[0];
        txd_oe_r <= 1'b1;
      end else begin
        txd_r    <= 1'b0;
        txd_oe_r <= !tx_shift_r[0];
      end
      rx_irq_r <= rx_ctrl_r[asp2_pkg::RX_IRQ_EN] && rx_ctrl_r[asp2_pkg::RX_DONE];
      tx_irq_r <= tx_ctrl_r[asp2_pkg::TX_IRQ_EN] && tx_ctrl_r[asp2_pkg::TX_LOADED];
    end
  end

  assign o_awready         = !aw_v_r;
  assign o_wready          = !w_v_r;
  assign o_bvalid          = bvalid_r;
  assign o_bresp           = bresp_r;
  assign o_arready         = arready_r;
  assign o_rvalid          = rvalid_r;
  assign o_rdata           = rdata_r;
  assign o_rresp           = rresp_r;
  assign o_transmit_pin    = txd_r;
  assign o_transmit_pin_oe = txd_oe_r;
  assign o_rx_irq          = rx_irq_r;
  assign o_tx_irq          = tx_irq_r;

  // ****************************************
  // Assertions
  // ****************************************
  baud_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (!rx_run && !tx_run) |=> (baud_acc_r == '0 && !half_tick_r))
    else $error("baud counter not cleared while idle");
  baud_rate_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    half_tick_r |-> (baud_acc_r < baud_thr))
    else $error("baud accumulator out of range");
  rx_irq_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (rx_ctrl_r[asp2_pkg::RX_IRQ_EN] && rx_ctrl_r[asp2_pkg::RX_DONE]) |=> o_rx_irq)
    else $error("receive interrupt missing");
  tx_irq_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_tx_irq |-> $past(tx_ctrl_r[asp2_pkg::TX_LOADED]))
    else $error("transmit interrupt without loaded flag");
  tx_loaded_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (tx_state_r == asp2_pkg::TX_LOAD) |=> tx_ctrl_r[asp2_pkg::TX_LOADED])
    else $error("loaded flag not set after shifter load");
  rx_end_done_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    rx_end |=> (rx_ctrl_r[asp2_pkg::RX_DONE] && !rx_run))
    else $error("receive end did not set done");
  rx_abort_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    rx_abort |=> (rx_ctrl_r[asp2_pkg::RX_DONE] && !rx_run))
    else $error("receive abort did not set done");
  tx_abort_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    tx_abort |=> (tx_state_r == asp2_pkg::TX_IDLE))
    else $error("transmit abort not immediate");
  tx_gap_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    tx_restart |=> (tx_state_r == asp2_pkg::TX_LOAD && tx_run) ##1
    (tx_state_r == asp2_pkg::TX_SEND))
    else $error("continuous restart gap wrong");
  tx_idle_pin_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (tx_state_r == asp2_pkg::TX_IDLE && !tx_abort) |=> tx_shift_r[0])
    else $error("transmit line not idle high");
  rx_cover_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) rx_end);
  rx_abort_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) rx_abort);
  tx_cont_c:  cover property (@(posedge i_ref_clk) disable iff (!i_resetn) tx_restart);
  tx_abort_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) tx_abort);
endmodule : asp2_uart

// >>> verif/asp2_remote.sv
`timescale 1ns/1ps
module asp2_remote #(
  parameter int BIT_CYC = 16
) (
  input  wire logic i_ref_clk,
  input  wire logic i_line,
  output logic      o_rx_line
);
  logic [7:0] got_byte = 8'h00;
  int         got_count = 0;
  initial o_rx_line = 1'b1;
  // Frame out: start, data LSB first, stop
  task automatic send(input logic [7:0] d, input logic stp);
    for (int i = -1; i < 9; i++) begin
      o_rx_line <= (i < 0) ? 1'b0 : (i > 7) ? stp : d[i];
      repeat (BIT_CYC) @(posedge i_ref_clk);
    end
    o_rx_line <= 1'b1;
  endtask : send
  // Frame in: sample each bit centre
  always begin
    @(negedge i_line);
    repeat (BIT_CYC / 2) @(posedge i_ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge i_ref_clk);
      got_byte[i] = i_line;
    end
    repeat (BIT_CYC) @(posedge i_ref_clk);
    got_count++;
  end
endmodule : asp2_remote

// >>> verif/asp2_uart_bench.sv
`timescale 1ns/1ps
module asp2_uart_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [17:0] awaddr = '0, araddr = '0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, tx_pin, tx_oe, rx_irq, tx_irq;
  logic        rx_line;
  logic [1:0]  bresp, rresp;
  logic [7:0]  d, d2;
  int          err_count = 0, compares = 0, seed = 32'h4605, c;
  wire         line = tx_oe ? tx_pin : 1'b1;
  always #2.5 clk = ~clk;
  asp2_uart DUT (.i_ref_clk(clk), .i_resetn(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_receive_pin(rx_line),
    .o_transmit_pin(tx_pin), .o_transmit_pin_oe(tx_oe), .o_rx_irq(rx_irq),
    .o_tx_irq(tx_irq));
  asp2_remote PEER (.i_ref_clk(clk), .i_line(line), .o_rx_line(rx_line));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] idx, input logic [7:0] v);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, 32'h0);
  endtask : wr
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rd(asp2_pkg::IDX_RX_CTRL + 16'(i), 32'h0, 2'h0);
    rd(16'h0100, 32'h0, 2'h2);
    $display("test registers done");
    wr(asp2_pkg::IDX_BAUD, 8'h05);
    for (int pp = 1; pp >= 0; pp--) begin
      d = 8'($random(seed));
      wr(asp2_pkg::IDX_TX_HOLD, d);
      wr(asp2_pkg::IDX_TX_CTRL, {3'b101, pp[0], 4'h1});
      c = PEER.got_count;
      for (int t = 0; t < 400 && PEER.got_count == c; t++) @(posedge clk);
      repeat (40) @(posedge clk);
      chk({24'h0, PEER.got_byte}, {24'h0, d});
      chk({31'h0, tx_irq}, 32'h1);
      rd(asp2_pkg::IDX_TX_CTRL, {3'b001, pp[0], 4'h3}, 2'h0);
      wr(asp2_pkg::IDX_TX_CTRL, 8'h00);
    end
    $display("test transmit done");
    d = 8'($random(seed));
    d2 = 8'($random(seed));
    wr(asp2_pkg::IDX_TX_HOLD, d);
    c = PEER.got_count;
    wr(asp2_pkg::IDX_TX_CTRL, 8'hb1);
    for (int t = 0; t < 400 && !tx_irq; t++) @(posedge clk);
    wr(asp2_pkg::IDX_TX_HOLD, d2);
    wr(asp2_pkg::IDX_TX_CTRL, 8'hb1);
    for (int t = 0; t < 400 && PEER.got_count == c; t++) @(posedge clk);
    chk({24'h0, PEER.got_byte}, {24'h0, d});
    for (int t = 0; t < 600 && PEER.got_count == c + 1; t++) @(posedge clk);
    repeat (40) @(posedge clk);
    chk({24'h0, PEER.got_byte}, {24'h0, d2});
    rd(asp2_pkg::IDX_TX_CTRL, 32'h0000_0033, 2'h0);
    wr(asp2_pkg::IDX_TX_CTRL, 8'h00);
    $display("test continuous done");
    wr(asp2_pkg::IDX_RX_CTRL, 8'h41);
    for (int s = 1; s >= 0; s--) begin
      d = 8'($random(seed));
      PEER.send(d, s[0]);
      repeat (20) @(posedge clk);
      chk({31'h0, rx_irq}, 32'h1);
      rd(asp2_pkg::IDX_RX_HOLD, {24'h0, d}, 2'h0);
      rd(asp2_pkg::IDX_RX_CTRL, {3'b010, ~s[0], 4'h3}, 2'h0);
      wr(asp2_pkg::IDX_RX_CTRL, 8'h41);
    end
    $display("test receive done");
    close_out();
  end
endmodule : asp2_uart_bench
